// *** fsr_pkg.sv ***
// Shared constants and carriers for the fail-safe start-up and release block
package fsr_pkg;
	localparam logic [15:0] FSR_RELEASE_WORD = 16'hB2A5;
	localparam logic [15:0] FSR_ANSWER_DEFAULT = 16'h5AB2;
	localparam logic [6:0] FSR_ADDR_DBG_MAIN = 7'h20;
	localparam logic [6:0] FSR_ADDR_DBG_FS = 7'h21;
	localparam logic [3:0] FSR_WIN_DISABLED = 4'h0;
	localparam logic [1:0] FSR_PAIR_MODE = 2'h1;
	localparam logic [2:0] FSR_GOOD_NEEDED = 3'h7;
	localparam logic [1:0] FSR_MAX_PROGRAMS = 2'h3;
	localparam logic [2:0] FSR_ERR_RESET = 3'h1;
	localparam int FSR_WIN_LSB = 0;

	typedef enum logic [3:0] {
		FSR_ST_IDLE = 4'b0001,
		FSR_ST_NOSTART = 4'b0010,
		FSR_ST_INIT = 4'b0100,
		FSR_ST_RUN = 4'b1000
	} fsr_state_t;

	// One configuration image, from mirrors or fuses
	typedef struct packed {
		logic wd_enabled;
		logic [6:0] i2c_addr;
		logic [6:0] i2c_addr_fs;
	} fsr_cfg_t;

	// Safety-input configuration fields
	typedef struct packed {
		logic [1:0] pair_cfg;
		logic pair_pol;
	} fsr_fault_cfg_t;
endpackage

// *** fsr_failsafe_release.sv ***
// Fail-safe start-up selection, watchdog gating and safe-state output release
// Notes on behaviour
// - At start-up the configuration is loaded from the mirror image when host writes filled it, else straight from the fuses.
// - Host-filled mirrors win, else programmed fuses, else the device refuses to start.
// - The regulator enable output is held off while in debug mode.
// - Before the first good watchdog answer the watchdog is stopped and regulators are not kept alive.
// - The safe-state output stays asserted at least until the host writes 1 to the debug-leave bit.
// - The fault error counter returns to zero only after seven consecutive good answers.
// - A zero window-period field disables the watchdog.
// - Fault-pair configuration value one with polarity bit 0 monitors the two fault inputs as a complementary pair.
// - With polarity bit 1 a low level on either fault input is a fault.
// - Writing the secure word to the release register releases the safe-state output high.
// - Release through the register works only when the fuse configuration enables the watchdog.
// - With the debug pin high the main logic answers 0x20 and the fail-safe logic 0x21.
// - A new address written to the mirror applies only once the debug pin has returned low.
// - In normal mode the address comes from the fuse configuration until a mirror address has been written.
// - The fuse configuration may be programmed at most three times.
module fsr_failsafe_release #(
	parameter int FAULT_CNT_W = 3
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic start_req,
	input wire logic debug_pin,
	input wire logic mirror_filled,
	input wire fsr_pkg::fsr_cfg_t mirror_cfg,
	input wire logic fuse_programmed,
	input wire fsr_pkg::fsr_cfg_t fuse_cfg,
	input wire logic mirror_addr_wr,
	input wire logic [6:0] mirror_addr_data,
	input wire logic answer_wr,
	input wire logic [15:0] watchdog_answer_word,
	input wire logic [15:0] expected_answer,
	input wire logic window_wr,
	input wire logic [15:0] watchdog_window_config,
	input wire logic input_cfg_wr,
	input wire fsr_pkg::fsr_fault_cfg_t safety_input_config,
	input wire logic state_wr,
	input wire logic debug_leave_bit,
	input wire logic release_wr,
	input wire logic [15:0] safe_output_release_reg,
	input wire logic fault_input_one,
	input wire logic fault_input_two,
	input wire logic fault_event,
	input wire logic program_req,
	output logic safe_state_output,
	output logic regulators_en,
	output logic keep_alive,
	output logic watchdog_running,
	output logic started,
	output logic start_refused,
	output logic init_closed,
	output logic debug_mode,
	output logic [FAULT_CNT_W-1:0] fault_error_counter,
	output logic fault_detected,
	output logic [6:0] i2c_addr_main,
	output logic [6:0] i2c_addr_fs,
	output logic program_grant,
	output logic [1:0] program_count
);
	fsr_pkg::fsr_state_t state_reg, state_next;
	fsr_pkg::fsr_cfg_t cfg_reg, cfg_next;
	fsr_pkg::fsr_fault_cfg_t fcfg_reg, fcfg_next;
	logic dbg_reg, dbg_next;
	logic release_reg, release_next;
	logic [3:0] win_reg, win_next;
	logic [2:0] streak_reg, streak_next;
	logic [FAULT_CNT_W-1:0] ferr_reg, ferr_next;
	logic [6:0] pend_addr_reg, pend_addr_next;
	logic pend_reg, pend_next;
	logic [6:0] addr_main_reg, addr_main_next;
	logic [6:0] addr_fs_reg, addr_fs_next;
	logic fault_reg, fault_next;
	logic [1:0] prog_cnt_reg, prog_cnt_next;
	logic grant_reg, grant_next;
	logic debug_pin_d_reg;
	logic good_answer;
	logic pair_fault;

	assign good_answer = answer_wr && (watchdog_answer_word == expected_answer);

	always_comb begin
		pair_fault = 1'b0;
		if (fcfg_reg.pair_cfg == fsr_pkg::FSR_PAIR_MODE) begin
			if (fcfg_reg.pair_pol) begin
				pair_fault = !fault_input_one || !fault_input_two;
			end else begin
				pair_fault = fault_input_one == fault_input_two;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		cfg_next = cfg_reg;
		fcfg_next = fcfg_reg;
		dbg_next = dbg_reg;
		release_next = release_reg;
		win_next = win_reg;
		streak_next = streak_reg;
		ferr_next = ferr_reg;
		pend_addr_next = pend_addr_reg;
		pend_next = pend_reg;
		addr_main_next = addr_main_reg;
		addr_fs_next = addr_fs_reg;
		fault_next = pair_fault;
		prog_cnt_next = prog_cnt_reg;
		grant_next = 1'b0;
		case (state_reg)
			fsr_pkg::FSR_ST_IDLE: begin
				if (start_req) begin
					if (mirror_filled) begin
						cfg_next = mirror_cfg;
						state_next = fsr_pkg::FSR_ST_INIT;
					end else if (fuse_programmed) begin
						cfg_next = fuse_cfg;
						state_next = fsr_pkg::FSR_ST_INIT;
					end else begin
						state_next = fsr_pkg::FSR_ST_NOSTART;
					end
				end
			end
			fsr_pkg::FSR_ST_NOSTART: begin
				// Stays refused until a reset retries selection
				state_next = fsr_pkg::FSR_ST_NOSTART;
			end
			fsr_pkg::FSR_ST_INIT: begin
				if (good_answer) begin
					state_next = fsr_pkg::FSR_ST_RUN;
				end
			end
			fsr_pkg::FSR_ST_RUN: begin
				state_next = fsr_pkg::FSR_ST_RUN;
			end
			default: begin
				state_next = fsr_pkg::FSR_ST_IDLE;
			end
		endcase
		if (window_wr) begin
			win_next = watchdog_window_config[fsr_pkg::FSR_WIN_LSB +: 4];
		end
		if (input_cfg_wr) begin
			fcfg_next = safety_input_config;
		end
		if (state_wr && debug_leave_bit) begin
			dbg_next = 1'b0;
		end
		// Streak only counts after initialization; wrong answer breaks it
		if (answer_wr && state_reg == fsr_pkg::FSR_ST_RUN) begin
			if (good_answer) begin
				if (streak_reg == fsr_pkg::FSR_GOOD_NEEDED - 3'h1) begin
					streak_next = 3'h0;
					ferr_next = '0;
				end else begin
					streak_next = streak_reg + 3'h1;
				end
			end else begin
				streak_next = 3'h0;
				if (ferr_reg != '1) begin
					ferr_next = ferr_reg + FAULT_CNT_W'(1);
				end
			end
		end
		// Fault event wins over the clearing streak so no error is lost
		if (fault_event || pair_fault) begin
			if (ferr_reg != '1) begin
				ferr_next = ferr_reg + FAULT_CNT_W'(1);
			end else begin
				ferr_next = ferr_reg;
			end
		end
		if (release_wr && safe_output_release_reg == fsr_pkg::FSR_RELEASE_WORD
			&& fuse_cfg.wd_enabled && fuse_programmed
			&& !dbg_reg && ferr_reg == '0 && state_reg == fsr_pkg::FSR_ST_RUN) begin
			release_next = 1'b1;
		end
		if (dbg_reg || ferr_next != '0 || fault_event || pair_fault) begin
			release_next = 1'b0;
		end
		if (mirror_addr_wr) begin
			pend_addr_next = mirror_addr_data;
			pend_next = 1'b1;
		end
		if (debug_pin) begin
			addr_main_next = fsr_pkg::FSR_ADDR_DBG_MAIN;
			addr_fs_next = fsr_pkg::FSR_ADDR_DBG_FS;
		end else if (debug_pin_d_reg && pend_reg) begin
			addr_main_next = pend_addr_reg;
			// Pending stays set so the fuse address never overrides a mirror address
			addr_fs_next = pend_addr_reg + 7'h01;
		end else if (!pend_reg && fuse_programmed && !debug_pin_d_reg) begin
			addr_main_next = fuse_cfg.i2c_addr;
			addr_fs_next = fuse_cfg.i2c_addr_fs;
		end
		if (program_req && prog_cnt_reg < fsr_pkg::FSR_MAX_PROGRAMS) begin
			prog_cnt_next = prog_cnt_reg + 2'h1;
			grant_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= fsr_pkg::FSR_ST_IDLE;
			cfg_reg <= '0;
			fcfg_reg <= '0;
			dbg_reg <= 1'b1;
			release_reg <= 1'b0;
			win_reg <= 4'h0;
			streak_reg <= 3'h0;
			ferr_reg <= FAULT_CNT_W'(fsr_pkg::FSR_ERR_RESET);
			pend_addr_reg <= 7'h00;
			pend_reg <= 1'b0;
			addr_main_reg <= fsr_pkg::FSR_ADDR_DBG_MAIN;
			addr_fs_reg <= fsr_pkg::FSR_ADDR_DBG_FS;
			fault_reg <= 1'b0;
			prog_cnt_reg <= 2'h0;
			grant_reg <= 1'b0;
			debug_pin_d_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cfg_reg <= cfg_next;
			fcfg_reg <= fcfg_next;
			dbg_reg <= dbg_next;
			release_reg <= release_next;
			win_reg <= win_next;
			streak_reg <= streak_next;
			ferr_reg <= ferr_next;
			pend_addr_reg <= pend_addr_next;
			pend_reg <= pend_next;
			addr_main_reg <= addr_main_next;
			addr_fs_reg <= addr_fs_next;
			fault_reg <= fault_next;
			prog_cnt_reg <= prog_cnt_next;
			grant_reg <= grant_next;
			debug_pin_d_reg <= debug_pin;
		end
	end

	// Output flops
	always_ff @(posedge core_clk) begin
		if (srst) begin
			safe_state_output <= 1'b0;
			regulators_en <= 1'b0;
			keep_alive <= 1'b0;
			watchdog_running <= 1'b0;
			started <= 1'b0;
			start_refused <= 1'b0;
			init_closed <= 1'b0;
			debug_mode <= 1'b1;
		end else begin
			safe_state_output <= release_next;
			regulators_en <= !dbg_next && state_next != fsr_pkg::FSR_ST_IDLE
				&& state_next != fsr_pkg::FSR_ST_NOSTART;
			keep_alive <= state_next == fsr_pkg::FSR_ST_RUN;
			watchdog_running <= state_next == fsr_pkg::FSR_ST_RUN
				&& win_next != fsr_pkg::FSR_WIN_DISABLED;
			started <= state_next == fsr_pkg::FSR_ST_INIT || state_next == fsr_pkg::FSR_ST_RUN;
			start_refused <= state_next == fsr_pkg::FSR_ST_NOSTART;
			init_closed <= state_next == fsr_pkg::FSR_ST_RUN;
			debug_mode <= dbg_next;
		end
	end

	assign fault_error_counter = ferr_reg;
	assign fault_detected = fault_reg;
	assign i2c_addr_main = addr_main_reg;
	assign i2c_addr_fs = addr_fs_reg;
	assign program_grant = grant_reg;
	assign program_count = prog_cnt_reg;
endmodule

// *** fsr_failsafe_release_asserts.sv ***
// Port-level checker for the fail-safe start-up and release block
module fsr_failsafe_release_asserts #(
	parameter int FAULT_CNT_W = 3
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic debug_pin,
	input wire logic fuse_programmed,
	input wire fsr_pkg::fsr_cfg_t fuse_cfg,
	input wire logic answer_wr,
	input wire logic [15:0] watchdog_answer_word,
	input wire logic [15:0] expected_answer,
	input wire logic release_wr,
	input wire logic [15:0] safe_output_release_reg,
	input wire logic safe_state_output,
	input wire logic regulators_en,
	input wire logic keep_alive,
	input wire logic watchdog_running,
	input wire logic started,
	input wire logic start_refused,
	input wire logic init_closed,
	input wire logic debug_mode,
	input wire logic [FAULT_CNT_W-1:0] fault_error_counter,
	input wire logic [6:0] i2c_addr_main,
	input wire logic [1:0] program_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wire good = answer_wr && watchdog_answer_word == expected_answer;
	// Release conditions the block must see at the taking edge, all but the run-state check
	wire rel_ok = release_wr && safe_output_release_reg == fsr_pkg::FSR_RELEASE_WORD && fuse_programmed
		&& fuse_cfg.wd_enabled && !debug_mode && fault_error_counter == '0;
	property p_dbg_off; debug_mode |-> !regulators_en; endproperty
	a_dbg_off: assert property (p_dbg_off) else $error("regulators on in debug");
	property p_dbg_safe; debug_mode |-> !safe_state_output; endproperty
	a_dbg_safe: assert property (p_dbg_safe) else $error("safe output released in debug");
	property p_init_gate; !init_closed |-> !keep_alive && !watchdog_running; endproperty
	a_init_gate: assert property (p_init_gate) else $error("watchdog before init closed");
	property p_refuse; start_refused |=> start_refused && !started; endproperty
	a_refuse: assert property (p_refuse) else $error("refused start left");
	property p_init_close; $rose(init_closed) |-> $past(good); endproperty
	a_init_close: assert property (p_init_close) else $error("init closed without good answer");
	property p_cnt_zero; fault_error_counter == '0 && $past(fault_error_counter) != '0 |-> $past(good); endproperty
	a_cnt_zero: assert property (p_cnt_zero) else $error("counter cleared without good answer");
	property p_release; $rose(safe_state_output) |-> $past(rel_ok); endproperty
	a_release: assert property (p_release) else $error("safe output released wrongly");
	property p_addr_hold; debug_pin && $past(debug_pin) |-> $stable(i2c_addr_main); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved with pin high");
	property p_prog_max; $past(program_count) == 2'h3 |-> program_count == 2'h3; endproperty
	a_prog_max: assert property (p_prog_max) else $error("program count past limit");
endmodule

bind fsr_failsafe_release fsr_failsafe_release_asserts #(.FAULT_CNT_W(FAULT_CNT_W)) u_chk (.core_clk, .srst,
	.debug_pin, .fuse_programmed, .fuse_cfg, .answer_wr, .watchdog_answer_word, .expected_answer, .release_wr,
	.safe_output_release_reg, .safe_state_output, .regulators_en, .keep_alive, .watchdog_running, .started,
	.start_refused, .init_closed, .debug_mode, .fault_error_counter, .i2c_addr_main, .program_count);

// *** fsr_host_model.sv ***
// Host-side model: watchdog answers and the release word
module fsr_host_model (
	input wire logic bad,
	input wire logic [15:0] junk,
	output logic [15:0] watchdog_answer_word,
	output logic [15:0] expected_answer,
	output logic [15:0] safe_output_release_reg
);
	// Low bit forced so a wrong word can never match by chance
	wire logic [15:0] flip = bad ? {junk[15:1], 1'b1} : 16'h0000;
	assign expected_answer = fsr_pkg::FSR_ANSWER_DEFAULT;
	assign watchdog_answer_word = fsr_pkg::FSR_ANSWER_DEFAULT ^ flip;
	assign safe_output_release_reg = fsr_pkg::FSR_RELEASE_WORD ^ flip;
endmodule

// *** fsr_failsafe_release_tb_top.sv ***
// Self-checking bench for the fail-safe start-up and release block
module fsr_failsafe_release_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, srst = 1'b1, debug_pin = 1'b1, mirror_filled = 1'b0, fuse_programmed = 1'b0;
	logic debug_leave_bit = 1'b0, fault_input_one = 1'b1, fault_input_two = 1'b1, bad = 1'b0, chk = 1'b0;
	logic [7:0] stb = 8'h00;
	logic [6:0] mirror_addr_data = 7'h00;
	logic [15:0] watchdog_window_config = 16'h0000, junk = 16'h0000;
	fsr_pkg::fsr_cfg_t mirror_cfg = '0, fuse_cfg = '0;
	fsr_pkg::fsr_fault_cfg_t safety_input_config = '0;
	wire logic [15:0] watchdog_answer_word, expected_answer, safe_output_release_reg;
	logic safe_state_output, regulators_en, keep_alive, watchdog_running, started, start_refused, init_closed;
	logic debug_mode, fault_detected;
	logic [2:0] fault_error_counter;
	logic [6:0] i2c_addr_main, i2c_addr_fs;
	logic [1:0] program_count;
	logic [12:0][6:0] o;
	int seed = 86212, n_mismatch = 0, checked = 0, qi[$];
	logic [6:0] qv[$];
	string nm[13] = '{"safe", "reg_en", "alive", "wd_run", "started", "refused", "init", "debug", "cnt_zero",
		"fault", "addr_main", "addr_fs", "prog_cnt"};
	assign o = {7'(program_count), i2c_addr_fs, i2c_addr_main, 7'(fault_detected), 7'(fault_error_counter == 3'h0),
		7'(debug_mode), 7'(init_closed), 7'(start_refused), 7'(started), 7'(watchdog_running), 7'(keep_alive),
		7'(regulators_en), 7'(safe_state_output)};
	fsr_failsafe_release #(.FAULT_CNT_W(3)) u_fsr_failsafe_release (.core_clk, .srst, .start_req(stb[0]),
		.debug_pin, .mirror_filled, .mirror_cfg, .fuse_programmed, .fuse_cfg, .mirror_addr_wr(stb[7]),
		.mirror_addr_data, .answer_wr(stb[1]), .watchdog_answer_word, .expected_answer, .window_wr(stb[4]),
		.watchdog_window_config, .input_cfg_wr(stb[5]), .safety_input_config, .state_wr(stb[2]), .debug_leave_bit,
		.release_wr(stb[3]), .safe_output_release_reg, .fault_input_one, .fault_input_two, .fault_event(1'b0),
		.program_req(stb[6]), .safe_state_output, .regulators_en, .keep_alive, .watchdog_running, .started,
		.start_refused, .init_closed, .debug_mode, .fault_error_counter, .fault_detected, .i2c_addr_main,
		.i2c_addr_fs, .program_grant(), .program_count);
	fsr_host_model u_fsr_host_model (.bad, .junk, .watchdog_answer_word, .expected_answer, .safe_output_release_reg);
	always #10 core_clk = ~core_clk;
	task cyc(int n);
		repeat (n) @(posedge core_clk);
	endtask
	task pls(int k);
		@(posedge core_clk) stb[k] <= 1'b1;
		@(posedge core_clk) stb[k] <= 1'b0;
	endtask
	task ex(int i, logic [6:0] v);
		qi.push_back(i);
		qv.push_back(v);
	endtask
	task chkq;
		@(posedge core_clk) chk <= 1'b1;
		@(posedge core_clk) chk <= 1'b0;
	endtask
	task ans(logic b, int n);
		repeat (n) begin
			bad <= b;
			junk <= 16'($random(seed));
			pls(1);
		end
		bad <= 1'b0;
	endtask
	task cmp(string s, logic [6:0] seen, logic [6:0] e);
		checked++;
		if (seen !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, seen);
		end
	endtask
	task end_sim;
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Mid-cycle sampling keeps the compare clear of the design's own edge
	always @(negedge core_clk) begin
		int i;
		while (chk && qi.size() > 0) begin
			i = qi.pop_front();
			cmp(nm[i], o[i], qv.pop_front());
		end
	end
	task rst;
		srst <= 1'b1;
		cyc(20);
		srst <= 1'b0;
	endtask
	task run(logic w);
		rst();
		fuse_programmed <= 1'b1;
		mirror_filled <= 1'b1;
		fuse_cfg <= {w, 14'($random(seed))};
		mirror_cfg <= {1'b1, 14'($random(seed))};
		pls(0);
		ex(4, 7'h01);
		ex(11, 7'h21);
		ans(1'b1, 1);
		ex(6, 7'h00);
		ex(2, 7'h00);
		chkq();
		ans(1'b0, 1);
		ex(2, 7'h01);
		pls(3);
		ex(0, 7'h00);
		ex(1, 7'h00);
		chkq();
		debug_leave_bit <= 1'b1;
		pls(2);
		ex(7, 7'h00);
		ex(1, 7'h01);
		ans(1'b1, 1);
		ans(1'b0, 6);
		ex(8, 7'h00);
		chkq();
		ans(1'b0, 1);
		ex(8, 7'h01);
		bad <= 1'b1;
		pls(3);
		ex(0, 7'h00);
		chkq();
		bad <= 1'b0;
		pls(3);
		ex(0, 7'(w));
		watchdog_window_config <= 16'h0201;
		pls(4);
		ex(3, 7'h01);
		chkq();
		watchdog_window_config <= 16'h0200;
		pls(4);
		ex(3, 7'h00);
		chkq();
	endtask
	initial begin
		cyc(4000);
		n_mismatch++;
		end_sim();
	end
	initial begin
		run(1'b0);
		run(1'b1);
		safety_input_config <= {2'h1, 1'b1};
		fault_input_one <= 1'b0;
		pls(5);
		cyc(1);
		ex(9, 7'h01);
		mirror_addr_data <= 7'($random(seed));
		pls(7);
		ex(10, 7'h20);
		chkq();
		debug_pin <= 1'b0;
		cyc(2);
		ex(10, mirror_addr_data);
		repeat (4) pls(6);
		ex(12, 7'h03);
		chkq();
		rst();
		mirror_filled <= 1'b0;
		fuse_programmed <= 1'b0;
		pls(0);
		ex(5, 7'h01);
		ex(4, 7'h00);
		chkq();
		end_sim();
	end
endmodule
